// ===== logic/bbse_pkg.sv
// constants and carriers for the branch and bit-set execute block
package bbse_pkg;
	localparam int PC_W   = 21;
	localparam int ADDR_W = 12;
	localparam int INSN_W = 16;

	// quarter phases of one instruction cycle, one-hot
	localparam logic [3:0] Q1 = 4'h1;
	localparam logic [3:0] Q2 = 4'h2;
	localparam logic [3:0] Q3 = 4'h4;
	localparam logic [3:0] Q4 = 4'h8;
	localparam logic [3:0] Q_RESET = 4'h1;

	// opcode fields
	localparam logic [7:0] OP_BR_NOT_ZERO = 8'he1;
	localparam logic [7:0] OP_BR_NO_OVF   = 8'he5;
	localparam logic [4:0] OP_BR_ALWAYS   = 5'h1a;
	localparam logic [3:0] OP_SET_BIT     = 4'h8;
	localparam int ACC_BIT = 8;
	localparam int BIT_LSB = 9;

	// file addressing
	localparam logic [7:0] ACC_LOW_LAST = 8'h5f;
	localparam logic [3:0] ACC_HIGH_PG  = 4'hf;
	localparam logic [3:0] ACC_LOW_PG   = 4'h0;

	// pc step to the next word
	localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

	// reset values
	localparam logic [INSN_W-1:0] IR_RESET   = 16'h0000;
	localparam logic [PC_W-1:0]   PC_RESET   = 21'h000000;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;
	localparam logic [7:0]        DATA_RESET = 8'h00;

	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_NOP = 2'b10
	} bbse_state_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
	} bbse_file_s;
endpackage

// ===== logic/bbse_qgen.sv
// quarter phase generator, one-hot Q1..Q4
`timescale 1ns/1ps
module bbse_qgen (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       ce_i,
	// phase
	output logic [3:0] q_o
);
	logic [3:0] q_ff;
	wire  [3:0] nxt_q = {q_ff[2:0], q_ff[3]};

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			q_ff <= bbse_pkg::Q_RESET;
		else if (ce_i)
			q_ff <= nxt_q;
	end

	assign q_o = q_ff;
endmodule

// ===== logic/bbse_exec.sv
// decode and execute of relative branches and the file bit set
// Behaviour
// [RULE1] branch if zero clear to pc plus 2n
// [RULE2] not taken one cycle, taken adds nop
// [RULE3] branch if overflow clear, else fall through
// [RULE4] eleven bit signed always branch to target
// [RULE5] always branch: pc written Q4, nop next
// [RULE6] target is word address plus 2 plus 2n
// [RULE7] set bit b of file f, flags untouched
// [RULE8] extended set, access, f<=5fh uses indexed
// [RULE9] access bit 0 access bank, 1 bsr bank
`timescale 1ns/1ps
module bbse_exec (
	// clock and reset
	input  wire logic                          clk_i,
	input  wire logic                          reset_n_i,
	input  wire logic                          ce_i,
	// fetch
	input  wire logic                          instr_valid_i,
	input  wire logic [bbse_pkg::INSN_W-1:0]   instr_i,
	input  wire logic [bbse_pkg::PC_W-1:0]     pc_i,
	output logic                               nop_cycle_o,
	// status and addressing context
	input  wire logic                          zero_flag_i,
	input  wire logic                          ovf_flag_i,
	input  wire logic [3:0]                    bsr_i,
	input  wire logic                          ext_set_en_i,
	input  wire logic [bbse_pkg::ADDR_W-1:0]   fsr2_i,
	output logic                               status_we_o,
	// program counter
	output logic                               pc_load_o,
	output logic [bbse_pkg::PC_W-1:0]          pc_target_o,
	// file register port
	output logic                               file_rd_o,
	output logic                               file_wr_o,
	output bbse_pkg::bbse_file_s               file_o,
	input  wire logic [7:0]                    file_rdata_i,
	// quarter phase
	output logic [3:0]                         q_o
);
	logic [3:0]                     q;
	bbse_pkg::bbse_state_e          state_ff;
	bbse_pkg::bbse_state_e          nxt_state;
	logic [bbse_pkg::INSN_W-1:0]    ir_ff;
	logic [bbse_pkg::PC_W-1:0]      pc_ff;
	logic                           vld_ff;
	logic                           taken_ff;
	logic [bbse_pkg::PC_W-1:0]      target_ff;
	bbse_pkg::bbse_file_s           file_ff;

	bbse_qgen u_qgen (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.ce_i      (ce_i),
		.q_o       (q)
	);

	// decode
	wire is_br_not_zero = ir_ff[15:8] == bbse_pkg::OP_BR_NOT_ZERO;
	wire is_br_no_ovf   = ir_ff[15:8] == bbse_pkg::OP_BR_NO_OVF;
	wire is_br_always   = ir_ff[15:11] == bbse_pkg::OP_BR_ALWAYS;
	wire is_set_bit     = ir_ff[15:12] == bbse_pkg::OP_SET_BIT;
	wire run     = state_ff == bbse_pkg::ST_RUN;

	// [RULE6] offset doubled, sign extended
	wire [bbse_pkg::PC_W-1:0] off_short = {{12{ir_ff[7]}}, ir_ff[7:0], 1'b0};
	wire [bbse_pkg::PC_W-1:0] off_long  = {{9{ir_ff[10]}}, ir_ff[10:0], 1'b0};
	wire [bbse_pkg::PC_W-1:0] off_sel   = is_br_always ? off_long : off_short;
	wire [bbse_pkg::PC_W-1:0] nxt_target = pc_ff + bbse_pkg::PC_STEP + off_sel;

	// [RULE1] [RULE3] [RULE4] branch condition
	wire nxt_taken = vld_ff & (is_br_always | (is_br_not_zero & ~zero_flag_i)
	                 | (is_br_no_ovf & ~ovf_flag_i));

	// file address forms
	wire [7:0]                    f_lit    = ir_ff[7:0];
	wire                          acc_a    = ir_ff[bbse_pkg::ACC_BIT];
	wire [2:0]                    bit_sel  = ir_ff[bbse_pkg::BIT_LSB+2:bbse_pkg::BIT_LSB];
	wire                          f_low    = f_lit <= bbse_pkg::ACC_LOW_LAST;
	wire [bbse_pkg::ADDR_W-1:0]   addr_bsr = {bsr_i, f_lit};
	wire [bbse_pkg::ADDR_W-1:0]   addr_idx = fsr2_i + {bbse_pkg::ACC_LOW_PG, f_lit};
	wire [bbse_pkg::ADDR_W-1:0]   addr_acc = f_low ? {bbse_pkg::ACC_LOW_PG, f_lit}
	                                               : {bbse_pkg::ACC_HIGH_PG, f_lit};
	// [RULE8] indexed literal offset
	wire                          use_idx  = ~acc_a & ext_set_en_i & f_low;
	// [RULE9] bank choice
	wire [bbse_pkg::ADDR_W-1:0]   nxt_addr = acc_a ? addr_bsr : (use_idx ? addr_idx : addr_acc);

	// bit mask, one term per bit
	logic [7:0] bit_mask;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_mask
			assign bit_mask[gi] = bit_sel == 3'(gi);
		end
	endgenerate

	// [RULE7] read-modify-write sets one bit
	wire [7:0] nxt_wdata = file_rdata_i | bit_mask;

	// [RULE2] taken branch spends next cycle as nop
	assign nxt_state = (q[3] & taken_ff) ? bbse_pkg::ST_NOP :
	                   (q[3] ? bbse_pkg::ST_RUN : state_ff);

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_ff <= bbse_pkg::ST_RUN;
			ir_ff    <= bbse_pkg::IR_RESET;
			pc_ff    <= bbse_pkg::PC_RESET;
			vld_ff   <= 1'b0;
		end else if (ce_i) begin
			state_ff <= nxt_state;
			if (q[0]) begin
				ir_ff  <= instr_i;
				pc_ff  <= pc_i;
				vld_ff <= instr_valid_i & run;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			file_ff.addr <= bbse_pkg::ADDR_RESET;
			file_ff.wdata <= bbse_pkg::DATA_RESET;
			target_ff <= bbse_pkg::PC_RESET;
			taken_ff <= 1'b0;
		end else if (ce_i) begin
			if (q[1])
				file_ff.addr <= nxt_addr;
			if (q[2]) begin
				file_ff.wdata <= nxt_wdata;
				target_ff <= nxt_target;
				taken_ff <= nxt_taken;
			end
		end
	end

	// [RULE5] pc written in Q4 of first cycle
	assign pc_load_o   = ce_i & q[3] & taken_ff;
	assign pc_target_o = target_ff;
	assign file_rd_o   = ce_i & q[2] & vld_ff & is_set_bit;
	assign file_wr_o   = ce_i & q[3] & vld_ff & is_set_bit;
	assign file_o      = file_ff;
	assign nop_cycle_o = ~run;
	// [RULE1] [RULE4] no flag writes from this block
	assign status_we_o = 1'b0;
	assign q_o         = q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	// doubled offsets for the branch checks
	wire [bbse_pkg::PC_W-1:0] chk_short = {{12{ir_ff[7]}}, ir_ff[7:0], 1'b0};
	wire [bbse_pkg::PC_W-1:0] chk_long  = {{9{ir_ff[10]}}, ir_ff[10:0], 1'b0};
	wire [bbse_pkg::PC_W-1:0] chk_base  = pc_ff + bbse_pkg::PC_STEP;

	// branch decisions
	property p_nz_taken;
		(ce_i && q[3] && vld_ff && is_br_not_zero && !$past(zero_flag_i))
			|-> (pc_load_o && pc_target_o == chk_base + chk_short);
	endproperty
	a_nz_taken: assert property (p_nz_taken) else $error("not-zero branch missed"); // [RULE1]

	property p_nz_fall;
		(ce_i && q[3] && vld_ff && is_br_not_zero && $past(zero_flag_i))
			|-> !pc_load_o ##1 (state_ff == bbse_pkg::ST_RUN);
	endproperty
	a_nz_fall: assert property (p_nz_fall) else $error("zero set, no fall through"); // [RULE2]

	property p_no_ovf;
		(ce_i && q[3] && vld_ff && is_br_no_ovf)
			|-> (pc_load_o == !$past(ovf_flag_i))
			&& (!pc_load_o || pc_target_o == chk_base + chk_short);
	endproperty
	a_no_ovf: assert property (p_no_ovf) else $error("overflow branch decision wrong"); // [RULE3]

	property p_always;
		(ce_i && q[3] && vld_ff && is_br_always)
			|-> (pc_load_o && pc_target_o == chk_base + chk_long);
	endproperty
	a_always: assert property (p_always) else $error("always branch wrong target"); // [RULE4]

	property p_nop_after;
		pc_load_o |=> (state_ff == bbse_pkg::ST_NOP) throughout (!pc_load_o && !file_wr_o)[*3];
	endproperty
	a_nop_after: assert property (p_nop_after) else $error("no nop after taken branch"); // [RULE5]

	property p_target_word;
		pc_load_o |-> (pc_target_o[0] == 1'b0)
			&& (pc_target_o - pc_ff == bbse_pkg::PC_STEP + (is_br_always ? chk_long : chk_short));
	endproperty
	a_target_word: assert property (p_target_word) else $error("bad target"); // [RULE6]

	// bit set data and addressing
	property p_read_write;
		file_rd_o |=> file_wr_o;
	endproperty
	a_read_write: assert property (p_read_write) else $error("no write after read"); // [RULE7]

	property p_set_write;
		file_rd_o |=> (file_o.wdata == ($past(file_rdata_i) | (8'h01 << bit_sel)));
	endproperty
	a_set_write: assert property (p_set_write) else $error("set bit data wrong"); // [RULE7]

	property p_indexed;
		(file_rd_o && !acc_a && f_low && $past(ext_set_en_i))
			|-> (file_o.addr == $past(fsr2_i) + {bbse_pkg::ACC_LOW_PG, f_lit});
	endproperty
	a_indexed: assert property (p_indexed) else $error("indexed address wrong"); // [RULE8]

	property p_banked;
		(file_rd_o && acc_a) |-> (file_o.addr == {$past(bsr_i), f_lit});
	endproperty
	a_banked: assert property (p_banked) else $error("bank address wrong"); // [RULE9]

	property p_acc_bank;
		(file_rd_o && !acc_a && !(f_low && $past(ext_set_en_i)))
			|-> (file_o.addr == {(f_low ? bbse_pkg::ACC_LOW_PG : bbse_pkg::ACC_HIGH_PG), f_lit});
	endproperty
	a_acc_bank: assert property (p_acc_bank) else $error("access bank address wrong"); // [RULE9]

	c_nz_taken: cover property (pc_load_o && is_br_not_zero);
	c_nz_fall:  cover property (ce_i && q[3] && vld_ff && is_br_not_zero && !pc_load_o);
	c_always:   cover property (pc_load_o && is_br_always);
	c_set_idx:  cover property (file_wr_o && use_idx);
endmodule

// ===== tb/bbse_file_model.sv
// far-side file register read port
`timescale 1ns/1ps
module bbse_file_model (
	// file port
	input  wire logic        file_rd_i,
	input  wire logic [11:0] addr_i,
	output logic [7:0]       rdata_o
);
	logic [7:0] last_ff = 8'h00;
	// off the read strobe the port shows the inverse of the last answer
	assign rdata_o = file_rd_i ? (addr_i[7:0] ^ 8'h5a) : ~last_ff;
	always @(negedge file_rd_i) last_ff = addr_i[7:0] ^ 8'h5a;
endmodule

// ===== tb/branch_and_bit_set_exec_test.sv
// self-checking bench for the branch and bit-set execute block
`timescale 1ns/1ps
module branch_and_bit_set_exec_test;
	logic                 clk_i = 0, reset_n_i = 0, valid = 0, zf = 0, of = 0, ext = 0, ce = 1;
	logic [15:0]          instr = '0;
	logic [20:0]          pc = '0;
	logic [3:0]           bsr = 4'h3;
	logic [11:0]          fsr2 = 12'h200;
	logic                 nop_o, swe, pld, frd, fwr;
	logic [20:0]          tgt;
	logic [7:0]           rdata;
	logic [3:0]           q;
	bbse_pkg::bbse_file_s fo;
	int                   fails = 0, n_compared = 0, cyc = 0;

	bbse_exec u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce),
		.instr_valid_i(valid), .instr_i(instr), .pc_i(pc), .nop_cycle_o(nop_o),
		.zero_flag_i(zf), .ovf_flag_i(of), .bsr_i(bsr), .ext_set_en_i(ext),
		.fsr2_i(fsr2), .status_we_o(swe), .pc_load_o(pld), .pc_target_o(tgt),
		.file_rd_o(frd), .file_wr_o(fwr), .file_o(fo), .file_rdata_i(rdata), .q_o(q));
	bbse_file_model u_file (.file_rd_i(frd), .addr_i(fo.addr), .rdata_o(rdata));

	initial forever #12.5 clk_i = ~clk_i;

	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge clk_i) if (++cyc > 2000) begin
		fails++;
		$display("BAD t=%0t timeout", $time);
		end_of_test();
	end

	task automatic chk(input logic [20:0] got, input logic [20:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// present a word at Q1, return at Q2
	task automatic issue(input logic [15:0] w, input logic [20:0] a);
		while (q !== bbse_pkg::Q1) @(negedge clk_i);
		instr = w;
		pc = a;
		valid = 1;
		@(negedge clk_i);
		valid = 0;
	endtask

	task automatic br(input logic [15:0] w, input logic [20:0] a, input logic tk);
		logic [20:0] e;
		e = a + 21'h2 + ((w[15:11] == 5'h1a) ? {{9{w[10]}}, w[10:0], 1'b0}
			: {{12{w[7]}}, w[7:0], 1'b0});
		issue(w, a);
		repeat (2) @(negedge clk_i);
		chk(pld, tk);
		chk(swe, 0);
		if (tk) chk(tgt, e);
		issue(16'h8e05, 21'h0);
		chk(nop_o, tk);
		@(negedge clk_i);
		chk(frd, !tk);
		$display("test branch %h done", w);
	endtask

	task automatic sb(input logic [15:0] w, input logic [11:0] ea);
		issue(w, 21'h0);
		@(negedge clk_i);
		chk(frd, 1);
		chk(21'(fo.addr), 21'(ea));
		@(negedge clk_i);
		chk(fwr, 1);
		chk(21'(fo.wdata), 21'((ea[7:0] ^ 8'h5a) | (8'h01 << w[11:9])));
		chk(swe, 0);
	endtask

	task automatic t_not_zero;
		zf = 0; of = 1; br(16'he180, 21'h000100, 1);
		zf = 1; of = 0; br(16'he17f, 21'h000100, 0);
	endtask

	task automatic t_no_ovf;
		of = 0; zf = 1; br(16'he57f, 21'h1ffffe, 1);
		of = 1; zf = 0; br(16'he580, 21'h000200, 0);
	endtask

	task automatic t_always;
		zf = 1; of = 1; br(16'hd400, 21'h000a00, 1);
		br(16'hd3ff, 21'h000010, 1);
	endtask

	// clock enable low in mid-instruction freezes the phase and the strobes
	task automatic t_hold;
		issue(16'hd001, 21'h000040);
		ce = 0;
		repeat (3) @(negedge clk_i);
		chk(21'(q), 21'(bbse_pkg::Q2));
		chk(pld, 0);
		ce = 1;
		repeat (2) @(negedge clk_i);
		chk(pld, 1);
		chk(tgt, 21'h000044);
		issue(16'h8e05, 21'h0);
		chk(nop_o, 1);
		$display("test clock hold done");
	endtask

	task automatic t_set_bit;
		for (int b = 0; b < 8; b++) sb({4'h8, 3'(b), 1'b1, 8'h12}, 12'h312);
		ext = 0; sb(16'h845f, 12'h05f);
		sb(16'h8460, 12'hf60);
		ext = 1; sb(16'h8c5f, 12'h25f);
		sb(16'h8c60, 12'hf60);
		$display("test set bit done");
	endtask

	initial begin
		repeat (2) @(negedge clk_i);
		chk(21'(q), 21'(bbse_pkg::Q1));
		reset_n_i = 1;
		t_not_zero();
		t_no_ovf();
		t_always();
		t_hold();
		t_set_bit();
		end_of_test();
	end
endmodule
